// *** sfwg_top.sv ***
// Write guard and operation timing core of a serial flash
// Behaviour
// - Page write up to 256 bytes, 2 ms busy
// - Every clear operation busy 8 ms, within 20
// - Status byte starts at zero, array erased
// - Reset lands in standby, nothing pending
// - Only complete well formed commands alter memory
// - Data-changing command must end on byte boundary
// - Data change needs write enable latch set
// - Guard bits mark a read-only region
// - Guard pin low refuses guard and lock changes
// - Deep sleep ignores all but wake command
// - Command touching guarded region is dropped whole
// - Large array, coarse guard step decoding
// - Large array, fine guard step decoding
// - Small array, coarse guard step decoding
// - Small array, fine guard step decoding
// - Opcodes 06h set, 04h clear the latch
// - Clear and page write opcodes and address bytes
// - Commands during busy are ignored harmlessly
//
// Added by the designer: the address map and the APB slave port.
module sfwg_top #(
	parameter int unsigned PROG_CYC = sfwg_pkg::PAGE_WRITE_CYC,
	parameter int unsigned CLEAR_CYC = sfwg_pkg::CLEAR_CYC,
	parameter int unsigned STATUS_CYC = sfwg_pkg::STATUS_CYC,
	parameter logic [7:0] SLEEP_OPC = 8'hb9,
	parameter logic [7:0] WAKE_OPC = 8'hab
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link pins
	input wire logic select_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic hw_guard_pin_n,
	// Operation request to the array
	output logic op_start,
	output logic [2:0] op_kind,
	output logic [23:0] op_addr,
	output logic [8:0] op_len,
	// Status
	output logic busy,
	output logic write_enable_latch,
	output logic [7:0] status_byte,
	output logic sleeping
);
	typedef enum logic [1:0] {ST_READY, ST_BUSY, ST_SLEEP} sfwg_state_t;

	sfwg_guard_if gif ();

	// Parameter sanity
	if (PROG_CYC == 0 || CLEAR_CYC == 0 || STATUS_CYC == 0) begin : g_bad_time
		$error("sfwg_top: busy durations must be at least one cycle");
	end

	logic [1:0] sel_s, clk_s, dat_s, pin_s; // Two-stage synchronisers
	logic sel_d, clk_d; // Edge history after the second stage
	logic sclk_rise, sel_fall, frame_end; // Link events
	logic [7:0] shreg, next_byte, opcode, status_data; // Shift data
	logic [2:0] bit_cnt; // Bits within the current byte
	logic [9:0] byte_cnt; // Whole bytes in the frame, saturating
	logic [23:0] addr; // Captured target address
	sfwg_state_t state;
	logic [31:0] timer; // Remaining busy cycles
	logic [4:0] guard_bits; // Region guard bits
	logic lock_bit; // Status lock bit
	logic [7:0] pend_status; // Status value waiting for completion
	logic small_density; // Control: 128 KB array
	logic [15:0] reject_cnt; // Refused data-changing commands
	logic [2:0] next_kind;
	logic len_ok, frame_whole, is_dc, in_ready, pin_ok;
	logic accept, reject, set_latch, clr_latch, go_sleep, wake, done;
	logic [17:0] op_size, top, lo, hi;
	logic [9:0] data_bytes;

	// Synchronisers; the first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_s <= 2'h3;
			clk_s <= 2'h0;
			dat_s <= 2'h0;
			pin_s <= 2'h3;
			sel_d <= 1'b1;
			clk_d <= 1'b0;
		end else begin
			sel_s <= {sel_s[0], select_n};
			clk_s <= {clk_s[0], sclk};
			dat_s <= {dat_s[0], sdi};
			pin_s <= {pin_s[0], hw_guard_pin_n};
			sel_d <= sel_s[1];
			clk_d <= clk_s[1];
		end
	end

	assign sclk_rise = clk_s[1] && !clk_d && !sel_s[1];
	assign sel_fall = !sel_s[1] && sel_d;
	assign frame_end = sel_s[1] && !sel_d;
	assign next_byte = {shreg[6:0], dat_s[1]};
	assign pin_ok = pin_s[1];

	// Bit and byte counting of the frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 10'h000;
		end else if (sel_fall) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 10'h000;
		end else if (sclk_rise) begin
			shreg <= next_byte;
			bit_cnt <= bit_cnt + 3'h1;
			// Saturate so an overlong write cannot wrap to a valid length
			if (bit_cnt == 3'h7 && byte_cnt != 10'h3ff) byte_cnt <= byte_cnt + 10'h001;
		end
	end

	// Opcode, address and status data capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opcode <= 8'h00;
			addr <= 24'h000000;
			status_data <= 8'h00;
		end else if (sclk_rise && bit_cnt == 3'h7) begin
			case (byte_cnt)
				10'h000: opcode <= next_byte;
				10'h001: begin
					addr[23:16] <= next_byte;
					status_data <= next_byte;
				end
				10'h002: addr[15:8] <= next_byte;
				10'h003: addr[7:0] <= next_byte;
				default: ;
			endcase
		end
	end

	// Command kind, expected length and target size
	always_comb begin
		next_kind = sfwg_pkg::KIND_NONE;
		len_ok = 1'b0;
		op_size = sfwg_pkg::SIZE_PAGE;
		case (opcode)
			sfwg_pkg::OPC_PAGE_WRITE: begin
				next_kind = sfwg_pkg::KIND_PAGE_WRITE;
				len_ok = byte_cnt >= 10'h005;
			end
			sfwg_pkg::OPC_PAGE_CLEAR: begin
				next_kind = sfwg_pkg::KIND_PAGE_CLEAR;
				len_ok = byte_cnt == 10'h004;
			end
			sfwg_pkg::OPC_FOUR_K_CLEAR: begin
				next_kind = sfwg_pkg::KIND_FOUR_K;
				len_ok = byte_cnt == 10'h004;
				op_size = sfwg_pkg::SIZE_4K;
			end
			sfwg_pkg::OPC_HALF_BLOCK_CLEAR: begin
				next_kind = sfwg_pkg::KIND_HALF_BLOCK;
				len_ok = byte_cnt == 10'h004;
				op_size = sfwg_pkg::SIZE_32K;
			end
			sfwg_pkg::OPC_FULL_BLOCK_CLEAR: begin
				next_kind = sfwg_pkg::KIND_FULL_BLOCK;
				len_ok = byte_cnt == 10'h004;
				op_size = sfwg_pkg::SIZE_64K;
			end
			sfwg_pkg::OPC_WHOLE_CLEAR_A, sfwg_pkg::OPC_WHOLE_CLEAR_B: begin
				next_kind = sfwg_pkg::KIND_WHOLE;
				len_ok = byte_cnt == 10'h001;
			end
			sfwg_pkg::OPC_STATUS_WRITE: begin
				next_kind = sfwg_pkg::KIND_STATUS;
				len_ok = byte_cnt == 10'h002;
			end
			default: ;
		endcase
	end

	// Target range, aligned down to the operation size
	assign top = small_density ? sfwg_pkg::TOP_SMALL : sfwg_pkg::TOP_LARGE;
	assign lo = (next_kind == sfwg_pkg::KIND_WHOLE) ? 18'h00000 :
		(addr[17:0] & top & ~(op_size - 18'h00001));
	assign hi = (next_kind == sfwg_pkg::KIND_WHOLE) ? top : (lo + op_size - 18'h00001);
	assign gif.guard_bits = guard_bits;
	assign gif.small_density = small_density;
	assign gif.op_lo = lo;
	assign gif.op_hi = hi;

	sfwg_region_decode u_decode (
		.g(gif.decoder_side)
	);

	// Frame judgement at select release
	assign in_ready = state == ST_READY;
	assign frame_whole = bit_cnt == 3'h0 && byte_cnt != 10'h000;
	assign is_dc = next_kind != sfwg_pkg::KIND_NONE && byte_cnt != 10'h000;
	// Status writes skip the region test; guarded range ends all others
	assign accept = frame_end && in_ready && is_dc && frame_whole && len_ok
		&& write_enable_latch
		&& (next_kind == sfwg_pkg::KIND_STATUS ? pin_ok : !gif.hit);
	assign reject = frame_end && in_ready && is_dc && !accept;
	assign set_latch = frame_end && in_ready && frame_whole && byte_cnt == 10'h001
		&& opcode == sfwg_pkg::OPC_SET_WL;
	assign clr_latch = frame_end && in_ready && frame_whole && byte_cnt == 10'h001
		&& opcode == sfwg_pkg::OPC_CLR_WL;
	assign go_sleep = frame_end && in_ready && frame_whole && byte_cnt == 10'h001
		&& opcode == SLEEP_OPC;
	assign wake = frame_end && state == ST_SLEEP && frame_whole && byte_cnt == 10'h001
		&& opcode == WAKE_OPC;
	assign done = state == ST_BUSY && timer == 32'h00000000;
	assign data_bytes = byte_cnt - 10'h004;

	// Operation state and busy timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_READY;
			busy <= 1'b0;
			sleeping <= 1'b0;
			timer <= 32'h00000000;
		end else begin
			case (state)
				ST_READY: begin
					if (accept) begin
						state <= ST_BUSY;
						busy <= 1'b1;
						if (next_kind == sfwg_pkg::KIND_PAGE_WRITE) timer <= PROG_CYC - 1;
						else if (next_kind == sfwg_pkg::KIND_STATUS) timer <= STATUS_CYC - 1;
						else timer <= CLEAR_CYC - 1;
					end else if (go_sleep) begin
						state <= ST_SLEEP;
						sleeping <= 1'b1;
					end
				end
				// Frames seen meanwhile are judged nowhere, so they do no harm
				ST_BUSY: begin
					if (done) begin
						state <= ST_READY;
						busy <= 1'b0;
					end else begin
						timer <= timer - 32'h00000001;
					end
				end
				ST_SLEEP: begin
					if (wake) begin
						state <= ST_READY;
						sleeping <= 1'b0;
					end
				end
				default: state <= ST_READY;
			endcase
		end
	end

	// Write enable latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) write_enable_latch <= 1'b0;
		else if (done || reject || clr_latch) write_enable_latch <= 1'b0;
		else if (set_latch) write_enable_latch <= 1'b1;
	end

	// Request towards the array, one-cycle start pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_start <= 1'b0;
			op_kind <= sfwg_pkg::KIND_NONE;
			op_addr <= 24'h000000;
			op_len <= 9'h000;
		end else begin
			op_start <= accept;
			if (accept) begin
				op_kind <= next_kind;
				op_addr <= {6'h00, lo};
				// Longer page writes keep only the last bytes of the page
				if (next_kind != sfwg_pkg::KIND_PAGE_WRITE) op_len <= 9'h000;
				else if (data_bytes >= 10'(sfwg_pkg::PAGE_MAX_BYTES))
					op_len <= 9'(sfwg_pkg::PAGE_MAX_BYTES);
				else op_len <= data_bytes[8:0];
			end
		end
	end

	// Guard and lock bits, written only when a status write completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			guard_bits <= sfwg_pkg::STATUS_RESET[sfwg_pkg::ST_GUARD_LSB +: 5];
			lock_bit <= sfwg_pkg::STATUS_RESET[sfwg_pkg::ST_LOCK_BIT];
			pend_status <= sfwg_pkg::STATUS_RESET;
		end else begin
			if (accept && next_kind == sfwg_pkg::KIND_STATUS) pend_status <= status_data;
			// Pin dropping mid-write still refuses the change
			if (done && op_kind == sfwg_pkg::KIND_STATUS && pin_ok) begin
				guard_bits <= pend_status[sfwg_pkg::ST_GUARD_LSB +: 5];
				lock_bit <= pend_status[sfwg_pkg::ST_LOCK_BIT];
			end
		end
	end

	// Status byte for the read path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) status_byte <= sfwg_pkg::STATUS_RESET;
		else status_byte <= {lock_bit, guard_bits, write_enable_latch, busy};
	end

	// Refusal counter, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) reject_cnt <= 16'h0000;
		else if (reject && reject_cnt != 16'hffff) reject_cnt <= reject_cnt + 16'h0001;
	end

	// APB slave: one wait state, write lands at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			small_density <= sfwg_pkg::CTRL_SMALL_RESET;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata <= 32'h00000000;
				pslverr <= 1'b0;
				case (paddr)
					sfwg_pkg::REG_CTRL: prdata[sfwg_pkg::CTRL_SMALL_BIT] <= small_density;
					sfwg_pkg::REG_STATUS: begin
						prdata[7:0] <= status_byte;
						prdata[sfwg_pkg::REG_SLEEP_BIT] <= sleeping;
						prdata[sfwg_pkg::REG_PIN_BIT] <= pin_ok;
					end
					sfwg_pkg::REG_REJECT: prdata[15:0] <= reject_cnt;
					sfwg_pkg::REG_LASTOP: prdata <= {op_addr, 5'h00, op_kind};
					default: pslverr <= 1'b1;
				endcase
			end else begin
				pslverr <= 1'b0;
			end
			if (psel && penable && pready && pwrite && paddr == sfwg_pkg::REG_CTRL)
				small_density <= pwdata[sfwg_pkg::CTRL_SMALL_BIT];
		end
	end

	// Checks
	logic [31:0] busy_len; // Cycles the current busy period has lasted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) busy_len <= 32'h00000000;
		else if (busy) busy_len <= busy_len + 32'h00000001;
		else busy_len <= 32'h00000000;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_prog_len;
		$fell(busy) && op_kind == sfwg_pkg::KIND_PAGE_WRITE |-> busy_len == PROG_CYC;
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("page write busy length wrong");
	property p_clear_len;
		$fell(busy) && op_kind inside {[sfwg_pkg::KIND_PAGE_CLEAR:sfwg_pkg::KIND_WHOLE]}
			|-> busy_len == CLEAR_CYC;
	endproperty
	a_clear_len: assert property (p_clear_len) else $error("clear busy length wrong");
	property p_needs_latch;
		op_start |-> $past(write_enable_latch) && $past(frame_whole) && busy;
	endproperty
	a_needs_latch: assert property (p_needs_latch) else $error("start without latch");
	property p_latch_drop;
		$fell(busy) |-> !write_enable_latch;
	endproperty
	a_latch_drop: assert property (p_latch_drop) else $error("latch kept after op");
	property p_sleep_quiet;
		$past(sleeping) |-> !op_start;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("op started in sleep");
	property p_busy_quiet;
		$past(busy) |-> !op_start;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("op started while busy");
	property p_no_guard_hit;
		op_start && op_kind != sfwg_pkg::KIND_STATUS |-> !$past(gif.hit);
	endproperty
	a_no_guard_hit: assert property (p_no_guard_hit) else $error("guarded target started");
	property p_pin_holds;
		!$stable(guard_bits) || !$stable(lock_bit) |-> $past(pin_ok) && $past(done);
	endproperty
	a_pin_holds: assert property (p_pin_holds) else $error("guard bits changed unlawfully");
	property p_busy_flag;
		op_start |-> busy ##1 status_byte[sfwg_pkg::ST_BUSY_BIT];
	endproperty
	a_busy_flag: assert property (p_busy_flag) else $error("busy not shown");
	c_page_write: cover property (op_start && op_kind == sfwg_pkg::KIND_PAGE_WRITE);
	c_guard_refused: cover property (reject && gif.hit);
	c_sleep_wake: cover property (wake);
	c_status_done: cover property (done && op_kind == sfwg_pkg::KIND_STATUS);
endmodule

// *** sfwg_pkg.sv ***
// Shared constants for the serial flash write guard
package sfwg_pkg;
	// Clock rate and operation times as specified
	localparam int CLK_MHZ = 200;
	localparam int PAGE_WRITE_TYP_MS = 2;
	localparam int PAGE_WRITE_MAX_MS = 3;
	localparam int CLEAR_TYP_MS = 8;
	localparam int CLEAR_MAX_MS = 20;
	localparam int STATUS_TYP_MS = 8;
	localparam int STATUS_MAX_MS = 12;
	// Busy durations in clock cycles, typical figures used
	localparam int PAGE_WRITE_CYC = PAGE_WRITE_TYP_MS * 1000 * CLK_MHZ;
	localparam int CLEAR_CYC = CLEAR_TYP_MS * 1000 * CLK_MHZ;
	localparam int STATUS_CYC = STATUS_TYP_MS * 1000 * CLK_MHZ;
	localparam int PAGE_MAX_BYTES = 256;
	// Command opcodes
	localparam logic [7:0] OPC_SET_WL = 8'h06;
	localparam logic [7:0] OPC_CLR_WL = 8'h04;
	localparam logic [7:0] OPC_PAGE_CLEAR = 8'h81;
	localparam logic [7:0] OPC_FOUR_K_CLEAR = 8'h20;
	localparam logic [7:0] OPC_HALF_BLOCK_CLEAR = 8'h52;
	localparam logic [7:0] OPC_FULL_BLOCK_CLEAR = 8'hd8;
	localparam logic [7:0] OPC_WHOLE_CLEAR_A = 8'h60;
	localparam logic [7:0] OPC_WHOLE_CLEAR_B = 8'hc7;
	localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	// Operation kinds reported to the array
	localparam logic [2:0] KIND_NONE = 3'h0;
	localparam logic [2:0] KIND_PAGE_WRITE = 3'h1;
	localparam logic [2:0] KIND_PAGE_CLEAR = 3'h2;
	localparam logic [2:0] KIND_FOUR_K = 3'h3;
	localparam logic [2:0] KIND_HALF_BLOCK = 3'h4;
	localparam logic [2:0] KIND_FULL_BLOCK = 3'h5;
	localparam logic [2:0] KIND_WHOLE = 3'h6;
	localparam logic [2:0] KIND_STATUS = 3'h7;
	// Array geometry
	localparam int ADDR_W = 18;
	localparam logic [17:0] SIZE_PAGE = 18'h00100;
	localparam logic [17:0] SIZE_4K = 18'h01000;
	localparam logic [17:0] SIZE_8K = 18'h02000;
	localparam logic [17:0] SIZE_16K = 18'h04000;
	localparam logic [17:0] SIZE_32K = 18'h08000;
	localparam logic [17:0] SIZE_64K = 18'h10000;
	localparam logic [17:0] SIZE_128K = 18'h20000;
	localparam logic [17:0] TOP_SMALL = 18'h1ffff;
	localparam logic [17:0] TOP_LARGE = 18'h3ffff;
	// Register offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_REJECT = 12'h008;
	localparam logic [11:0] REG_LASTOP = 12'h00c;
	// Field positions of the status byte, the status register and the control register
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_GUARD_LSB = 2;
	localparam int ST_LOCK_BIT = 7;
	localparam int REG_SLEEP_BIT = 8;
	localparam int REG_PIN_BIT = 9;
	localparam int CTRL_SMALL_BIT = 0;
	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic CTRL_SMALL_RESET = 1'b0;
endpackage

// *** sfwg_guard_if.sv ***
// Carrier between the write guard core and its region decoder
interface sfwg_guard_if;
	logic [4:0] guard_bits; // Region guard bits
	logic small_density; // 1 for the 128 KB array
	logic [17:0] op_lo; // First byte the command touches
	logic [17:0] op_hi; // Last byte the command touches
	logic hit; // Target overlaps the guarded region
	modport decoder_side (input guard_bits, input small_density, input op_lo, input op_hi,
		output hit);
	modport core_side (output guard_bits, output small_density, output op_lo, output op_hi,
		input hit);
endinterface

// *** sfwg_region_decode.sv ***
// Decoder from region guard bits to a guarded range and overlap test
module sfwg_region_decode (
	// Guard request and answer
	sfwg_guard_if.decoder_side g
);
	logic guarded; // Some region is guarded
	logic all_guarded; // Whole array guarded
	logic [17:0] sz; // Guarded size in bytes
	logic [17:0] top; // Last array address
	logic [17:0] lo; // Guarded range start
	logic [17:0] hi; // Guarded range end

	// Size selection and placement
	always_comb begin
		guarded = 1'b1;
		all_guarded = 1'b0;
		sz = sfwg_pkg::SIZE_4K;
		top = g.small_density ? sfwg_pkg::TOP_SMALL : sfwg_pkg::TOP_LARGE;
		if (!g.guard_bits[4]) begin
			// Quarter and half steps; bit 2 plays no part
			case (g.guard_bits[1:0])
				2'h0: guarded = 1'b0;
				2'h1: sz = sfwg_pkg::SIZE_64K;
				2'h2: begin
					// Small array: bit 1 alone already guards all of it
					if (g.small_density) all_guarded = 1'b1;
					else sz = sfwg_pkg::SIZE_128K;
				end
				default: all_guarded = 1'b1;
			endcase
		end else begin
			// Fine steps from 4 KB to 32 KB
			case (g.guard_bits[2:0])
				3'h0: guarded = 1'b0;
				3'h1: sz = sfwg_pkg::SIZE_4K;
				3'h2: sz = sfwg_pkg::SIZE_8K;
				3'h3: sz = sfwg_pkg::SIZE_16K;
				3'h7: all_guarded = 1'b1;
				default: sz = sfwg_pkg::SIZE_32K;
			endcase
		end
		// Bit 3 picks the bottom end, else the top end
		if (all_guarded) begin
			lo = '0;
			hi = top;
		end else if (g.guard_bits[3]) begin
			lo = '0;
			hi = sz - 18'h00001;
		end else begin
			lo = top - sz + 18'h00001;
			hi = top;
		end
	end

	// Any overlap with the guarded range refuses the command
	assign g.hit = guarded && (g.op_lo <= hi) && (g.op_hi >= lo);
endmodule

// *** sfwg_host_model.sv ***
// Serial host model that frames commands on the link pins
module sfwg_host_model (
	// Link pins toward the guard
	output logic select_n,
	output logic sclk,
	output logic sdi
);
	timeunit 1ns;
	timeprecision 1ps;
	bit powered = 1'b0; // Supply settled and wait done
	// Select held high through the power-up wait
	initial begin
		select_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		#150us powered = 1'b1;
	end
	// Shift nb bits MSB first in mode 0; clock stands still between frames
	task automatic send(input logic [47:0] d, input int nb);
		wait (powered);
		// Step off the pclk edge so the pins never race the synchronisers
		#1;
		select_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			sdi = d[47-i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 select_n = 1'b1;
		sdi = ~sdi; // Released line must not show stale data
		#500;
	endtask
endmodule

// *** sfwg_tb_top.sv ***
// Self-checking bench for the serial flash write guard
module sfwg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PROG_N = 20; // Shortened busy counts
	localparam int unsigned CLEAR_N = 600; // Long enough to frame a command inside
	localparam int unsigned STATUS_N = 30;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic hw_guard_pin_n = 1'b1;
	logic [31:0] prdata, rd;
	logic pready, pslverr, re, select_n, sclk, sdi, op_start, wr_latch, busy, sleeping;
	logic [2:0] op_kind;
	logic [23:0] op_addr;
	logic [8:0] op_len;
	logic [7:0] status_byte;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	int starts = 0;
	int busy_len = 0;
	int busy_run = 0;
	logic [7:0] opc [6] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
	logic [2:0] knd [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};
	logic [23:0] aln [6] = '{24'h012300, 24'h012000, 24'h010000, 24'h010000, 24'h0, 24'h0};
	// Guard probes: density and accepted as bit strings, status data, opcode, address
	logic [0:9] pb_sm = 10'h090;
	logic [7:0] pb_sd [10] = '{8'h04, 8'h04, 8'h04, 8'h44, 8'h44, 8'h44, 8'h18, 8'h4c, 8'h54,
		8'h24};
	logic [7:0] pb_op [10] = '{8'hd8, 8'hd8, 8'hd8, 8'h20, 8'h20, 8'h20, 8'hd8, 8'h20, 8'h20,
		8'h20};
	logic [23:0] pb_a [10] = '{24'h030000, 24'h010000, 24'h010000, 24'h03f000, 24'h03e000,
		24'h01f000, 24'h020000, 24'h03c000, 24'h038000, 24'h000000};
	logic [0:9] pb_ok = 10'h120;
	always #2.5 pclk = ~pclk;
	sfwg_top #(.PROG_CYC(PROG_N), .CLEAR_CYC(CLEAR_N), .STATUS_CYC(STATUS_N)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.select_n(select_n), .sclk(sclk), .sdi(sdi), .hw_guard_pin_n(hw_guard_pin_n),
		.op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_len(op_len),
		.busy(busy), .write_enable_latch(wr_latch), .status_byte(status_byte),
		.sleeping(sleeping));
	sfwg_host_model host_u (.select_n(select_n), .sclk(sclk), .sdi(sdi));
	// Count accepted operations, busy run lengths and the hang limit
	always @(posedge pclk) begin
		cycles++;
		if (op_start === 1'b1) starts++;
		if (busy === 1'b1) busy_run++;
		else if (busy_run != 0) begin
			busy_len = busy_run;
			busy_run = 0;
		end
		if (cycles > 90000) begin
			fails++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wait for the operation to end, bounded
	task automatic idle();
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge pclk);
		repeat (3) @(posedge pclk);
	endtask
	task automatic frame(input logic [47:0] d, input int nb, input int es, input int eb);
		int s;
		s = starts;
		busy_len = 0;
		host_u.send(d, nb);
		idle();
		check("op starts", es, starts - s);
		check("busy length", eb, busy_len);
	endtask
	task automatic set_latch();
		frame({8'h06, 40'h0}, 8, 0, 0);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h004, 0); check("status", 32'h200, rd);
		apb(1, 12'h000, 1);
		apb(0, 12'h000, 0); check("ctrl", 1, rd);
		apb(1, 12'h000, 0);
		apb(0, 12'h010, 0); check("unmapped error", 1, re);
		frame({8'h20, 24'h001234, 16'h0}, 32, 0, 0);
		apb(0, 12'h008, 0); check("rejects", 1, rd);
		set_latch(); check("latch set", 1, wr_latch);
		frame({8'h04, 40'h0}, 8, 0, 0); check("latch clear", 0, wr_latch);
		// Every clear opcode, aligned target
		for (int i = 0; i < 6; i++) begin
			set_latch();
			frame({opc[i], (i < 4 ? 24'h012345 : 24'h0), 16'h0}, i < 4 ? 32 : 8, 1,
				CLEAR_N);
			check("op kind", knd[i], op_kind);
			check("op addr", aln[i], op_addr);
			check("latch after op", 0, wr_latch);
		end
		// Clear-latch command framed while a clear runs must not touch the latch
		set_latch();
		host_u.send({8'h20, 40'h0}, 32);
		host_u.send({8'h04, 40'h0}, 8);
		check("busy meanwhile", 1, busy);
		check("latch kept in busy", 1, wr_latch);
		idle(); check("latch after busy", 0, wr_latch);
		set_latch();
		frame({8'h20, 24'h001000, 16'h0}, 33, 0, 0); check("latch dropped", 0, wr_latch);
		set_latch();
		frame({8'h20, 24'h0010, 16'h0}, 24, 0, 0);
		set_latch();
		frame({8'h02, 24'h000010, 16'haa55}, 48, 1, PROG_N);
		check("page len", 2, op_len);
		check("page kind", 1, op_kind);
		apb(0, 12'h00c, 0); check("lastop", 32'h00000001, rd);
		for (int i = 0; i < 10; i++) begin
			apb(1, 12'h000, {31'h0, pb_sm[i]});
			set_latch();
			frame({8'h01, pb_sd[i], 32'h0}, 16, 1, STATUS_N);
			check("guard bits", pb_sd[i][6:2], status_byte[6:2]);
			set_latch();
			frame({pb_op[i], pb_a[i], 16'h0}, 32, pb_ok[i],
				pb_ok[i] ? CLEAR_N : 0);
		end
		hw_guard_pin_n <= 1'b0;
		set_latch();
		frame({8'h01, 8'h00, 32'h0}, 16, 0, 0); check("pin guard", 5'h09, status_byte[6:2]);
		hw_guard_pin_n <= 1'b1;
		apb(0, 12'h008, 0); check("rejects total", 12, rd);
		frame({8'hb9, 40'h0}, 8, 0, 0); check("asleep", 1, sleeping);
		set_latch(); check("latch asleep", 0, wr_latch);
		frame({8'hab, 40'h0}, 8, 0, 0); check("awake", 0, sleeping);
		conclude();
	end
endmodule
